//--- core/hlc_pkg.sv
// Shared constants, field layouts and carrier types of the loop/OTP control bank
package hlc_pkg;
    // Register word indexes; the byte address is four times the index
    localparam logic [5:0] HLC_IDX_CTL4 = 6'h1E;
    localparam logic [5:0] HLC_IDX_CTL5 = 6'h1F;
    // Bus geometry
    localparam int HLC_AW = 8;
    localparam int HLC_DW = 32;
    // First register: field positions
    localparam int HLC_C4_ZC_LSB   = 6;
    localparam int HLC_C4_CAL_LSB  = 4;
    localparam int HLC_C4_STAT_BIT = 2;
    localparam int HLC_C4_PROG_BIT = 0;
    // Second register: field positions
    localparam int HLC_C5_ATT_LSB  = 6;
    localparam int HLC_C5_AUTO_BIT = 5;
    localparam int HLC_C5_PLAY_BIT = 4;
    localparam int HLC_C5_BLK_LSB  = 2;
    localparam int HLC_C5_DIS_LSB  = 0;
    // Reset values
    localparam logic [7:0] HLC_C4_RST = 8'h20;
    localparam logic [7:0] HLC_C5_RST = 8'h80;
    // Clock rate in kHz, used to turn times into cycles
    localparam longint HLC_CLK_KHZ = 25000;
    // Zero-cross windows in us (least times, rounded up)
    localparam longint HLC_ZC_US0 = 100;
    localparam longint HLC_ZC_US1 = 200;
    localparam longint HLC_ZC_US2 = 300;
    localparam longint HLC_ZC_US3 = 390;
    // Calibration durations in ms (the least of each range)
    localparam longint HLC_CAL_MS0 = 150;
    localparam longint HLC_CAL_MS1 = 250;
    localparam longint HLC_CAL_MS2 = 500;
    localparam longint HLC_CAL_MS3 = 1000;
    // Playback step intervals in ms
    localparam longint HLC_PLAY_MS0 = 5;
    localparam longint HLC_PLAY_MS1 = 1;
    // Open-loop period unit in units of 10 ns (98.46 us), rounded down
    localparam longint HLC_OL_UNIT_10NS = 9846;
    localparam int HLC_OL_UNIT_CYC = int'((HLC_OL_UNIT_10NS * HLC_CLK_KHZ) / 100000);
    // Base count of synchronisation attempts
    localparam logic [2:0] HLC_ATT_BASE = 3'h3;
    // Nonvolatile image: five configuration bytes
    localparam int HLC_OTP_WORDS = 5;
    localparam logic [2:0] HLC_OTP_LAST = 3'h4;
    localparam int HLC_TW = 25;
    // First register layout
    typedef struct packed {
        logic [1:0] zero_cross_window;
        logic [1:0] cal_duration;
        logic       rsv3;
        logic       otp_programmed;
        logic       rsv1;
        logic       otp_launch;
    } hlc_ctl4_t;
    // Second register layout
    typedef struct packed {
        logic [1:0] sync_attempt_limit;
        logic       auto_fallback_enable;
        logic       playback_fast;
        logic [1:0] sense_blank_hi;
        logic [1:0] current_dissipate_hi;
    } hlc_ctl5_t;
endpackage

//--- core/hlc_timer.sv
// Down-counter: busy for exactly len cycles, one-cycle done, optional reload
`timescale 1ns/100ps
module hlc_timer
    import hlc_pkg::*;
#(
    parameter int W = HLC_TW
)(
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         start,
    input  wire logic [W-1:0] len,
    output logic              busy,
    output logic              done
);
    logic [W-1:0] cnt;          // Cycles left
    logic [W-1:0] next_cnt;
    logic         next_busy;
    logic         next_done;

    // Load on start when idle; a start held in the last busy cycle reloads,
    // so a free-running period is exactly len cycles with no idle gap
    always_comb
    begin
        next_cnt  = cnt;
        next_busy = busy;
        next_done = 1'b0;
        if (busy)
        begin
            if (cnt == W'(1))
            begin
                next_done = 1'b1;
                // Reload without dropping busy
                if (start && len != '0)
                    next_cnt = len;
                else
                    next_busy = 1'b0;
            end
            else
                next_cnt = cnt - W'(1);
        end
        else if (start && len != '0)
        begin
            next_cnt  = len;
            next_busy = 1'b1;
        end
    end

    // State registers, frozen while ce is low
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt  <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (ce)
        begin
            cnt  <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end
endmodule // hlc_timer

//--- core/hlc_otp_mem.sv
// Small nonvolatile image store; read data leave through a register
`timescale 1ns/100ps
module hlc_otp_mem
    import hlc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       we,
    input  wire logic [2:0] waddr,
    input  wire logic [7:0] wdata,
    input  wire logic [2:0] raddr,
    output logic [7:0]      rdata
);
    logic [7:0] mem [HLC_OTP_WORDS];   // Fused bytes
    logic [7:0] next_rdata;

    // Out-of-range reads return zero
    always_comb
    begin
        next_rdata = (int'(raddr) < HLC_OTP_WORDS) ? mem[raddr] : 8'h00;
    end

    // Writes and registered read
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata <= 8'h00;
            for (int i = 0; i < HLC_OTP_WORDS; i++)
                mem[i] <= 8'h00;
        end
        else if (ce)
        begin
            rdata <= next_rdata;
            if (we && int'(waddr) < HLC_OTP_WORDS)
                mem[waddr] <= wdata;
        end
    end
endmodule // hlc_otp_mem

//--- core/hlc_regs.sv
// Loop timing, fallback, playback and OTP control bank behind a Wishbone slave
// Summary of operation
// - Window code picks 100/200/300/390 us minimum
// - Calibration code picks 150/250/500/1000 ms run
// - Bit 2 reads one once OTP programmed
// - Launch bit copies configuration bytes into OTP
// - OTP programming succeeds only once between resets
// - Fallback after 3 to 6 failed attempts
// - Fallback bit enables open loop without back-EMF
// - Playback step every 5 ms or 1 ms
// - Bits 3-2 are blanking period high bits
// - Bits 1-0 are dissipation period high bits
// - Open-loop period is field times 98.46 us
`timescale 1ns/100ps
module hlc_regs
    import hlc_pkg::*;
#(
    parameter int ZC_CYC0   = int'((HLC_ZC_US0 * HLC_CLK_KHZ + 999) / 1000),
    parameter int ZC_CYC1   = int'((HLC_ZC_US1 * HLC_CLK_KHZ + 999) / 1000),
    parameter int ZC_CYC2   = int'((HLC_ZC_US2 * HLC_CLK_KHZ + 999) / 1000),
    parameter int ZC_CYC3   = int'((HLC_ZC_US3 * HLC_CLK_KHZ + 999) / 1000),
    parameter int CAL_CYC0  = int'(HLC_CAL_MS0 * HLC_CLK_KHZ),
    parameter int CAL_CYC1  = int'(HLC_CAL_MS1 * HLC_CLK_KHZ),
    parameter int CAL_CYC2  = int'(HLC_CAL_MS2 * HLC_CLK_KHZ),
    parameter int CAL_CYC3  = int'(HLC_CAL_MS3 * HLC_CLK_KHZ),
    parameter int PLAY_CYC0 = int'(HLC_PLAY_MS0 * HLC_CLK_KHZ),
    parameter int PLAY_CYC1 = int'(HLC_PLAY_MS1 * HLC_CLK_KHZ)
)(
    input  wire logic              CLK_SYS,
    input  wire logic              RST,
    input  wire logic              CE,
    // Wishbone classic slave
    input  wire logic              CYC_I,
    input  wire logic              STB_I,
    input  wire logic              WE_I,
    input  wire logic [HLC_AW-1:0] ADR_I,
    input  wire logic [3:0]        SEL_I,
    input  wire logic [HLC_DW-1:0] DAT_I,
    output logic [HLC_DW-1:0]      DAT_O,
    output logic                   ACK_O,
    // Drive engine side
    input  wire logic              LRA_MODE,
    input  wire logic              CYCLE_TICK,
    input  wire logic              BEMF_SEEN,
    input  wire logic              ZC_START,
    input  wire logic              CAL_START,
    input  wire logic              PLAY_EN,
    input  wire logic [6:0]        FIXED_DRIVE_PERIOD,
    input  wire logic [1:0]        SENSE_BLANK_LO,
    input  wire logic [1:0]        CURRENT_DISSIPATE_LO,
    input  wire logic [39:0]       CFG_IMAGE,
    input  wire logic [2:0]        OTP_RD_ADDR,
    output logic [7:0]             OTP_RD_DATA,
    output logic                   ZC_WINDOW_BUSY,
    output logic                   CAL_BUSY,
    output logic                   PLAY_STEP,
    output logic                   OPEN_LOOP,
    output logic                   OL_DRIVE_TICK,
    output logic [3:0]             SENSE_BLANK_PERIOD,
    output logic [3:0]             CURRENT_DISSIPATE_PERIOD
);
    // OTP programming sequence
    typedef enum logic [1:0] {OTP_IDLE, OTP_COPY, OTP_DONE} hlc_otp_st_t;

    hlc_ctl4_t   ctl4;             // First register
    hlc_ctl5_t   ctl5;             // Second register
    hlc_ctl4_t   next_ctl4;
    hlc_ctl5_t   next_ctl5;
    logic [HLC_DW-1:0] next_dat;
    logic        next_ack;
    hlc_otp_st_t otp_st;           // Programming state
    hlc_otp_st_t next_otp_st;
    logic [2:0]  otp_idx;          // Byte being fused
    logic [2:0]  next_otp_idx;
    logic        otp_we;           // Store strobe this cycle
    logic [2:0]  miss_cnt;         // Drive cycles without back-EMF
    logic [2:0]  next_miss_cnt;
    logic        next_open;
    logic [3:0]  next_blank;
    logic [3:0]  next_diss;
    logic        play_busy;
    logic        ol_busy;
    logic        wr_req;           // Write taken this cycle
    logic        rd_ok;            // Index lands on a register
    logic [5:0]  idx;              // Word index of the access
    logic        fb_armed;         // Fallback armed at the shortest limit

    // Attempt limit: code plus three
    function automatic logic [2:0] att_limit(input logic [1:0] code);
        return HLC_ATT_BASE + {1'b0, code};
    endfunction

    // Zero-cross window length for a code
    function automatic logic [HLC_TW-1:0] zc_len(input logic [1:0] code);
        unique case (code)
            2'h0: return HLC_TW'(ZC_CYC0);
            2'h1: return HLC_TW'(ZC_CYC1);
            2'h2: return HLC_TW'(ZC_CYC2);
            2'h3: return HLC_TW'(ZC_CYC3);
        endcase
    endfunction

    // Calibration length for a code
    function automatic logic [HLC_TW-1:0] cal_len(input logic [1:0] code);
        unique case (code)
            2'h0: return HLC_TW'(CAL_CYC0);
            2'h1: return HLC_TW'(CAL_CYC1);
            2'h2: return HLC_TW'(CAL_CYC2);
            2'h3: return HLC_TW'(CAL_CYC3);
        endcase
    endfunction

    assign idx    = ADR_I[HLC_AW-1:2];
    assign wr_req = CYC_I && STB_I && WE_I && !ACK_O && SEL_I[0];
    assign rd_ok  = (idx == HLC_IDX_CTL4) || (idx == HLC_IDX_CTL5);
    assign fb_armed = ctl5.auto_fallback_enable && LRA_MODE
                      && ctl5.sync_attempt_limit == 2'h0;

    // Bus answer: one ack per request, a cycle after it is seen
    always_comb
    begin
        next_ack = CYC_I && STB_I && !ACK_O;
        next_dat = '0;
        if (idx == HLC_IDX_CTL4)
            next_dat[7:0] = ctl4;
        else if (idx == HLC_IDX_CTL5)
            next_dat[7:0] = ctl5;
    end

    // Register writes and the OTP sequence
    always_comb
    begin
        next_ctl4    = ctl4;
        next_ctl5    = ctl5;
        next_otp_st  = otp_st;
        next_otp_idx = otp_idx;
        otp_we       = 1'b0;
        if (wr_req && idx == HLC_IDX_CTL4)
        begin
            next_ctl4.zero_cross_window = DAT_I[HLC_C4_ZC_LSB +: 2];
            next_ctl4.cal_duration      = DAT_I[HLC_C4_CAL_LSB +: 2];
            if (otp_st == OTP_IDLE && DAT_I[HLC_C4_PROG_BIT])
            begin
                next_ctl4.otp_launch = 1'b1;
                next_otp_st          = OTP_COPY;
                next_otp_idx         = 3'h0;
            end
        end
        if (wr_req && idx == HLC_IDX_CTL5)
            next_ctl5 = DAT_I[7:0];
        // Copy one byte per cycle; launch bit stays set until done
        if (otp_st == OTP_COPY)
        begin
            otp_we = 1'b1;
            if (otp_idx == HLC_OTP_LAST)
            begin
                next_ctl4.otp_programmed = 1'b1;
                next_ctl4.otp_launch     = 1'b0;
                next_otp_st              = OTP_DONE;
            end
            else
                next_otp_idx = otp_idx + 3'h1;
        end
        next_ctl4.rsv3 = 1'b0;
        next_ctl4.rsv1 = 1'b0;
    end

    // Fallback decision and period concatenation
    always_comb
    begin
        next_miss_cnt = miss_cnt;
        next_open     = OPEN_LOOP;
        next_blank    = {ctl5.sense_blank_hi, SENSE_BLANK_LO};
        next_diss     = {ctl5.current_dissipate_hi, CURRENT_DISSIPATE_LO};
        if (!ctl5.auto_fallback_enable || !LRA_MODE)
        begin
            next_miss_cnt = 3'h0;
            next_open     = 1'b0;
        end
        else if (CYCLE_TICK)
        begin
            if (BEMF_SEEN)
            begin
                next_miss_cnt = 3'h0;
                next_open     = 1'b0;
            end
            else if (miss_cnt + 3'h1 >= att_limit(ctl5.sync_attempt_limit))
            begin
                next_miss_cnt = att_limit(ctl5.sync_attempt_limit);
                next_open     = 1'b1;
            end
            else
                next_miss_cnt = miss_cnt + 3'h1;
        end
    end

    // All state of the top, frozen while CE is low
    always_ff @(posedge CLK_SYS or posedge RST)
    begin
        if (RST)
        begin
            ctl4                     <= HLC_C4_RST;
            ctl5                     <= HLC_C5_RST;
            DAT_O                    <= '0;
            ACK_O                    <= 1'b0;
            otp_st                   <= OTP_IDLE;
            otp_idx                  <= 3'h0;
            miss_cnt                 <= 3'h0;
            OPEN_LOOP                <= 1'b0;
            SENSE_BLANK_PERIOD       <= 4'h0;
            CURRENT_DISSIPATE_PERIOD <= 4'h0;
        end
        else if (CE)
        begin
            ctl4                     <= next_ctl4;
            ctl5                     <= next_ctl5;
            DAT_O                    <= next_dat;
            ACK_O                    <= next_ack;
            otp_st                   <= next_otp_st;
            otp_idx                  <= next_otp_idx;
            miss_cnt                 <= next_miss_cnt;
            OPEN_LOOP                <= next_open;
            SENSE_BLANK_PERIOD       <= next_blank;
            CURRENT_DISSIPATE_PERIOD <= next_diss;
        end
    end

    // Fused image; CFG_IMAGE byte 0 is the lowest configuration address
    hlc_otp_mem u_otp (
        .clk   (CLK_SYS),
        .rst   (RST),
        .ce    (CE),
        .we    (otp_we),
        .waddr (otp_idx),
        .wdata (CFG_IMAGE[otp_idx*8 +: 8]),
        .raddr (OTP_RD_ADDR),
        .rdata (OTP_RD_DATA)
    );

    hlc_timer u_zc (
        .clk   (CLK_SYS),
        .rst   (RST),
        .ce    (CE),
        .start (ZC_START && !ZC_WINDOW_BUSY),
        .len   (zc_len(ctl4.zero_cross_window)),
        .busy  (ZC_WINDOW_BUSY),
        .done  ()
    );

    hlc_timer u_cal (
        .clk   (CLK_SYS),
        .rst   (RST),
        .ce    (CE),
        .start (CAL_START && !CAL_BUSY),
        .len   (cal_len(ctl4.cal_duration)),
        .busy  (CAL_BUSY),
        .done  ()
    );

    // playback step interval; restarts itself while enabled
    // Reload rides on the last busy cycle, so no idle cycle stretches the step
    hlc_timer u_play (
        .clk   (CLK_SYS),
        .rst   (RST),
        .ce    (CE),
        .start (PLAY_EN),
        .len   (ctl5.playback_fast ? HLC_TW'(PLAY_CYC1) : HLC_TW'(PLAY_CYC0)),
        .busy  (play_busy),
        .done  (PLAY_STEP)
    );

    // open-loop drive period; a zero field gives no ticks
    hlc_timer u_ol (
        .clk   (CLK_SYS),
        .rst   (RST),
        .ce    (CE),
        .start (OPEN_LOOP),
        .len   (HLC_TW'(FIXED_DRIVE_PERIOD) * HLC_TW'(HLC_OL_UNIT_CYC)),
        .busy  (ol_busy),
        .done  (OL_DRIVE_TICK)
    );

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST || !CE);

    // Request seen while no ack is out
    sequence s_req;
        CYC_I && STB_I && !ACK_O;
    endsequence

    // One missed drive cycle while armed, then a quiet armed cycle
    sequence s_miss;
        fb_armed && CYCLE_TICK && !BEMF_SEEN ##1 fb_armed && !CYCLE_TICK;
    endsequence

    a_bus_ack_once: assert property (s_req |=> ACK_O ##1 !ACK_O)
        else $error("ack not a single cycle after request");
    a_reserved_zero: assert property (!ctl4.rsv3 && !ctl4.rsv1)
        else $error("reserved bits not zero");
    a_otp_sticky: assert property (ctl4.otp_programmed |=> ctl4.otp_programmed)
        else $error("programmed flag dropped");
    a_otp_once: assert property (otp_st == OTP_DONE |=> !ctl4.otp_launch)
        else $error("second programming started");
    a_otp_copy_len: assert property ($rose(ctl4.otp_launch) |-> ##5 ctl4.otp_programmed)
        else $error("copy did not finish in five cycles");
    a_fallback_off: assert property (!ctl5.auto_fallback_enable |=> !OPEN_LOOP)
        else $error("open loop without fallback enable");
    a_fallback_bemf: assert property (CYCLE_TICK && BEMF_SEEN |=> !OPEN_LOOP)
        else $error("open loop despite back-EMF");
    a_blank_hi: assert property (SENSE_BLANK_PERIOD[3:2] == $past(ctl5.sense_blank_hi))
        else $error("blanking high bits wrong");
    a_diss_hi: assert property (CURRENT_DISSIPATE_PERIOD[3:2] == $past(ctl5.current_dissipate_hi))
        else $error("dissipation high bits wrong");
    a_zc_start: assert property (ZC_START && !ZC_WINDOW_BUSY |=> ZC_WINDOW_BUSY [*3])
        else $error("zero-cross window too short");
    a_cal_start: assert property (CAL_START && !CAL_BUSY |=> CAL_BUSY [*8])
        else $error("calibration ended early");
    a_play_pulse: assert property (PLAY_STEP |=> !PLAY_STEP)
        else $error("playback step longer than a cycle");
    a_ol_closed: assert property (!OPEN_LOOP && !ol_busy |=> !OL_DRIVE_TICK)
        else $error("drive tick in closed loop");
    a_miss_limit: assert property (
        miss_cnt == 3'h0 ##0 s_miss ##1 s_miss ##1 s_miss |=> OPEN_LOOP)
        else $error("no fallback after three misses");
    a_ack_needs_req: assert property (!(CYC_I && STB_I) |=> !ACK_O)
        else $error("ack without a request");
    a_open_needs_lra: assert property (!LRA_MODE |=> !OPEN_LOOP)
        else $error("open loop outside LRA operation");
    a_launch_excl: assert property (ctl4.otp_launch |-> !ctl4.otp_programmed)
        else $error("launch set after programming");
    a_play_running: assert property (PLAY_EN |=> play_busy)
        else $error("playback timer idle while enabled");
endmodule // hlc_regs

//--- tb/hlc_regs_tb.sv
// Self-checking bench of the loop timing, fallback, playback and OTP control bank
`timescale 1ns/100ps
module hlc_regs_tb;
    import hlc_pkg::*;
    // Shortened counts so each timed run lasts a few cycles
    localparam int ZN[4] = '{4, 5, 6, 7};
    localparam int CN[4] = '{10, 12, 14, 16};
    localparam int PN[2] = '{20, 8};
    localparam logic [7:0] A_C4 = 8'h78;  // Byte address of first register
    localparam logic [7:0] A_C5 = 8'h7C;  // Byte address of second register
    localparam logic [7:0] A_NONE = 8'h80;  // Unmapped word
    localparam logic [39:0] IMG = 40'h5A_C3_96_3C_A5;
    logic clk_sys, rst, ce, cyc, stb, we_i, lra_mode, cycle_tick, bemf_seen;
    logic zc_start, cal_start, play_en;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_i, rd;
    logic [6:0]  fixed_period;
    logic [1:0]  blank_lo, diss_lo;
    logic [39:0] cfg_image;
    logic [2:0]  otp_addr;
    wire  [31:0] dat_o;
    wire  [7:0]  otp_data;
    wire  [3:0]  blank_per, diss_per;
    wire         ack, zc_busy, cal_busy, play_step, open_loop, ol_tick;
    int          fails, n_tests, n, i;
    // Design with short timers; bus answers one cycle after a request
    hlc_regs #(
        .ZC_CYC0(ZN[0]), .ZC_CYC1(ZN[1]), .ZC_CYC2(ZN[2]), .ZC_CYC3(ZN[3]),
        .CAL_CYC0(CN[0]), .CAL_CYC1(CN[1]), .CAL_CYC2(CN[2]), .CAL_CYC3(CN[3]),
        .PLAY_CYC0(PN[0]), .PLAY_CYC1(PN[1])
    ) i_hlc_regs (
        .CLK_SYS(clk_sys), .RST(rst), .CE(ce), .CYC_I(cyc), .STB_I(stb), .WE_I(we_i),
        .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack),
        .LRA_MODE(lra_mode), .CYCLE_TICK(cycle_tick), .BEMF_SEEN(bemf_seen),
        .ZC_START(zc_start), .CAL_START(cal_start), .PLAY_EN(play_en),
        .FIXED_DRIVE_PERIOD(fixed_period), .SENSE_BLANK_LO(blank_lo),
        .CURRENT_DISSIPATE_LO(diss_lo), .CFG_IMAGE(cfg_image), .OTP_RD_ADDR(otp_addr),
        .OTP_RD_DATA(otp_data), .ZC_WINDOW_BUSY(zc_busy), .CAL_BUSY(cal_busy),
        .PLAY_STEP(play_step), .OPEN_LOOP(open_loop), .OL_DRIVE_TICK(ol_tick),
        .SENSE_BLANK_PERIOD(blank_per), .CURRENT_DISSIPATE_PERIOD(diss_per)
    );
    // Free-running 25 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Verdict and end of run, also reached on a bus timeout
    task automatic tally_and_finish();
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Single comparison; an unknown never matches
    task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    // One classic Wishbone cycle; waits for ack under a bound
    task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] wd);
        int k;
        @(posedge clk_sys);
        cyc <= 1'b1; stb <= 1'b1; we_i <= we; adr <= a; sel <= 4'h1; dat_i <= wd;
        for (k = 0; k < 50; k++)
        begin
            @(posedge clk_sys);
            if (ack === 1'b1)
                break;
        end
        rd = dat_o;
        cyc <= 1'b0; stb <= 1'b0; we_i <= 1'b0;
        // A missing ack ends the run rather than hanging it
        if (k == 50)
        begin
            expect_eq(32'h0, 32'h1);
            tally_and_finish();
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        wb_cycle(1'b0, a, 32'h0);
        expect_eq(rd, exp);
    endtask
    // Watched output picked by index
    function automatic logic watched(input int w);
        case (w)
            0: return zc_busy;
            1: return cal_busy;
            2: return play_step;
            default: return ol_tick;
        endcase
    endfunction
    // Fires a timer start pulse and counts the busy cycles that follow
    task automatic timed_run(input int w, output int cnt);
        int k;
        cnt = 0;
        @(posedge clk_sys);
        if (w == 0) zc_start <= 1'b1; else cal_start <= 1'b1;
        @(posedge clk_sys);
        zc_start <= 1'b0; cal_start <= 1'b0;
        for (k = 0; k < 100; k++)
        begin
            @(negedge clk_sys);
            if (watched(w) === 1'b1) cnt++;
            else if (cnt > 0) break;
        end
    endtask
    // Cycles between two pulses; a stuck-low output gives a count of 6000
    task automatic gap(input int w, output int cnt);
        int k;
        cnt = 0;
        for (k = 0; k < 6000; k++)
        begin
            @(negedge clk_sys);
            if (watched(w) === 1'b1) break;
        end
        for (k = 0; k < 6000; k++)
        begin
            @(negedge clk_sys);
            cnt++;
            if (watched(w) === 1'b1) break;
        end
    endtask
    // One drive-cycle tick, with or without back-EMF
    task automatic tick(input logic b);
        @(posedge clk_sys);
        cycle_tick <= 1'b1; bemf_seen <= b;
        @(posedge clk_sys);
        cycle_tick <= 1'b0;
    endtask
    task automatic settle_chk(input logic got_sel, input logic exp);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        expect_eq({31'h0, open_loop}, {31'h0, exp});
    endtask
    // Main sequence
    initial
    begin
        fails = 0; n_tests = 0;
        rst = 1'b1; ce = 1'b1; cyc = 1'b0; stb = 1'b0; we_i = 1'b0; adr = 8'h0;
        sel = 4'h0; dat_i = 32'h0; lra_mode = 1'b0; cycle_tick = 1'b0; bemf_seen = 1'b0;
        zc_start = 1'b0; cal_start = 1'b0; play_en = 1'b0; fixed_period = 7'h0;
        blank_lo = 2'h0; diss_lo = 2'h0; cfg_image = IMG; otp_addr = 3'h0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values, reserved bits and unmapped space
        rd_chk(A_C4, 32'h20);
        rd_chk(A_C5, 32'h80);
        wb_cycle(1'b1, A_C4, 32'hFE);
        rd_chk(A_C4, 32'hF0);
        wb_cycle(1'b1, A_NONE, 32'hFF);
        rd_chk(A_NONE, 32'h0);
        // Zero-cross window and calibration length for every code
        for (i = 0; i < 4; i++)
        begin
            wb_cycle(1'b1, A_C4, 32'(i << 6) | 32'(i << 4));
            timed_run(0, n);
            expect_eq(n, ZN[i]);
            timed_run(1, n);
            expect_eq(n, CN[i]);
        end
        // Playback step interval, both settings; the first gap may straddle the change
        @(posedge clk_sys);
        play_en <= 1'b1;
        for (i = 0; i < 2; i++)
        begin
            wb_cycle(1'b1, A_C5, 32'h80 | 32'(i << 4));
            gap(2, n);
            gap(2, n);
            expect_eq(n, PN[i]);
        end
        @(posedge clk_sys);
        play_en <= 1'b0;
        // Upper period bits joined with the lower bits from outside
        blank_lo <= 2'h2; diss_lo <= 2'h3;
        wb_cycle(1'b1, A_C5, 32'h8D);
        repeat (2) @(posedge clk_sys);
        expect_eq(blank_per, 32'hE);
        expect_eq(diss_per, 32'h7);
        blank_lo <= 2'h1; diss_lo <= 2'h0;
        wb_cycle(1'b1, A_C5, 32'h86);
        repeat (2) @(posedge clk_sys);
        expect_eq(blank_per, 32'h5);
        expect_eq(diss_per, 32'h8);
        // Fallback after 3+code missed cycles, cleared when back-EMF returns
        lra_mode <= 1'b1; fixed_period <= 7'h1;
        for (i = 0; i < 4; i++)
        begin
            wb_cycle(1'b1, A_C5, 32'(i << 6) | 32'h20);
            repeat (2 + i) tick(1'b0);
            settle_chk(1'b0, 1'b0);
            tick(1'b0);
            settle_chk(1'b0, 1'b1);
            if (i == 3)
            begin
                gap(3, n);
                gap(3, n);
                expect_eq(n, HLC_OL_UNIT_CYC);
            end
            tick(1'b1);
            settle_chk(1'b0, 1'b0);
        end
        // Three evenly spaced misses at the shortest limit
        wb_cycle(1'b1, A_C5, 32'h20);
        repeat (3) tick(1'b0);
        settle_chk(1'b0, 1'b1);
        // Disabled fallback, or a non-LRA actuator, never goes open loop
        wb_cycle(1'b1, A_C5, 32'hC0);
        repeat (7) tick(1'b0);
        settle_chk(1'b0, 1'b0);
        @(posedge clk_sys);
        lra_mode <= 1'b0;
        wb_cycle(1'b1, A_C5, 32'h20);
        repeat (7) tick(1'b0);
        settle_chk(1'b0, 1'b0);
        // One-time copy of the configuration bytes
        wb_cycle(1'b1, A_C4, 32'h21);
        repeat (10) @(posedge clk_sys);
        rd_chk(A_C4, 32'h24);
        for (i = 0; i < 6; i++)
        begin
            otp_addr <= 3'(i);
            repeat (2) @(posedge clk_sys);
            expect_eq(otp_data, (i < 5) ? 32'(IMG[8*i +: 8]) : 32'h0);
        end
        // A second launch changes nothing and the flag stays set
        cfg_image <= ~IMG;
        otp_addr <= 3'h0;
        wb_cycle(1'b1, A_C4, 32'h21);
        repeat (10) @(posedge clk_sys);
        rd_chk(A_C4, 32'h24);
        expect_eq(otp_data, 32'hA5);
        wb_cycle(1'b1, A_C4, 32'h20);
        rd_chk(A_C4, 32'h24);
        tally_and_finish();
    end
endmodule  // hlc_regs_tb
